/* rtl/zcb_branch_unit.sv */
// decode and execute of the four zero-compare branches
// assumes instructions arrive one per cycle with the register operand read;
// the delay slot is the next issued instruction after a branch
`timescale 1ns/10ps
`include "zcb_consts.svh"
module zcb_branch_unit
  import zcb_pkg::*;
(
  // clock and reset
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  // issue side
  input  wire zcb_issue_t issue_in,
  input  wire logic    mode64_in,
  // results
  output zcb_redirect_t redirect_out,
  output zcb_link_t    link_out,
  output logic         nullify_out,
  output logic         slot_out
);

  function automatic zcb_dec_t zcb_decode(input logic [31:0] w);
    logic [5:0] op;
    logic [4:0] rt;
    zcb_dec_t   d;
    op = w[`ZCB_OP_HI:`ZCB_OP_LO];
    rt = w[`ZCB_RT_HI:`ZCB_RT_LO];
    d  = '0;
    if (op == `ZCB_OP_REGISTER_IMMEDIATE_OPCODE_GROUP && rt == `ZCB_RT_NN_LINK) begin
      d.valid  = 1'b1;
      d.link   = 1'b1;
      d.likely = 1'b1;
    end else if (op == `ZCB_OP_REGISTER_IMMEDIATE_OPCODE_GROUP && rt == `ZCB_RT_NN) begin
      d.valid  = 1'b1;
      d.likely = 1'b1;
    end else if (op == `ZCB_OP_POS && rt == `ZCB_RT_ZERO) begin
      d.valid    = 1'b1;
      d.positive = 1'b1;
    end else if (op == `ZCB_OP_POS_LK && rt == `ZCB_RT_ZERO) begin
      d.valid    = 1'b1;
      d.positive = 1'b1;
      d.likely   = 1'b1;
    end
    return d;
  endfunction

  // 32-bit mode addresses live sign-extended in the 64-bit program counter
  function automatic logic [63:0] zcb_fit(input logic [63:0] a,
                                          input logic        m64);
    return m64 ? a : {{32{a[31]}}, a[31:0]};
  endfunction

  zcb_dec_t      dec_w;
  logic          cond_w;
  logic          take_w;
  logic [63:0]   disp_w;
  logic [63:0]   slot_pc_w;
  logic [63:0]   target_w;
  logic [63:0]   ret_w;
  logic [15:0]   ofs_w;

  zcb_state_t    st_r;
  zcb_state_t    st_nxt;
  zcb_redirect_t red_r;
  zcb_redirect_t red_nxt;
  zcb_link_t     link_r;
  zcb_link_t     link_nxt;
  logic          null_r;
  logic          null_nxt;
  logic          slot_r;
  logic          slot_nxt;

  zcb_cond u_cond (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .rs_data_in  (issue_in.rs_data),
    .mode64_in   (mode64_in),
    .positive_in (dec_w.positive),
    .cond_out    (cond_w)
  );

  always_comb begin
    dec_w  = zcb_decode(issue_in.word);
    ofs_w  = issue_in.word[`ZCB_OFS_HI:0];
    if (mode64_in) begin
      disp_w = {{`ZCB_EXT64{ofs_w[15]}}, ofs_w, 2'b00};
    end else begin
      disp_w = {{32{ofs_w[15]}},
                {`ZCB_EXT32{ofs_w[15]}}, ofs_w, 2'b00};
    end
    slot_pc_w = issue_in.pc + `ZCB_SLOT_OFS;
    target_w  = zcb_fit(slot_pc_w + disp_w, mode64_in);
    ret_w     = zcb_fit(issue_in.pc + `ZCB_LINK_OFS, mode64_in);
    // an instruction in a slot is never decoded as a branch; a killed slot
    // must leave no trace, and a branch in a live slot is undefined anyway
    take_w = issue_in.valid && dec_w.valid
             && (st_r == ZCB_ST_IDLE);
  end

  always_comb begin
    red_nxt.valid = take_w && cond_w;
    red_nxt.pc    = take_w ? target_w : red_r.pc;
    null_nxt      = take_w && dec_w.likely && !cond_w;
    // source register 31 is not checked: the write simply goes ahead
    link_nxt.we   = take_w && dec_w.link;
    link_nxt.idx  = `ZCB_LINK_IDX;
    link_nxt.data = (take_w && dec_w.link) ? ret_w : link_r.data;
    // slot flag has its own flop so the output comes straight from a register
    slot_nxt      = take_w;
    st_nxt        = ZCB_ST_IDLE;
    if (take_w) begin
      st_nxt = null_nxt ? ZCB_ST_KILL : ZCB_ST_SLOT;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r   <= ZCB_ST_IDLE;
      red_r  <= '0;
      link_r <= '0;
      null_r <= 1'b0;
      slot_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      red_r  <= red_nxt;
      link_r <= link_nxt;
      null_r <= null_nxt;
      slot_r <= slot_nxt;
    end
  end

  assign redirect_out = red_r;
  assign link_out     = link_r;
  assign nullify_out  = null_r;
  assign slot_out     = slot_r;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_disp_narrow: assert property (
    !mode64_in |-> disp_w[31:18] == {14{issue_in.word[15]}}
                   && disp_w[17:2] == issue_in.word[15:0]
                   && disp_w[1:0] == 2'b00)
    else $error("32-bit displacement badly formed");

  a_disp_wide: assert property (
    mode64_in |-> disp_w[63:18] == {46{issue_in.word[15]}}
                  && disp_w[17:2] == issue_in.word[15:0])
    else $error("64-bit displacement badly formed");

  a_decode_link: assert property (
    (issue_in.word[31:26] == 6'h01 && issue_in.word[20:16] == 5'h13)
      |-> dec_w.valid && dec_w.link && dec_w.likely)
    else $error("linking likely branch not decoded");

  a_decode_nn: assert property (
    (issue_in.word[31:26] == 6'h01 && issue_in.word[20:16] == 5'h03)
      |-> dec_w.valid && !dec_w.link && !dec_w.positive)
    else $error("likely not-negative branch not decoded");

  a_decode_pos: assert property (
    (issue_in.word[31:26] == 6'h07 && issue_in.word[20:16] == 5'h00)
      |-> dec_w.valid && dec_w.positive && !dec_w.likely)
    else $error("plain positive branch not decoded");

  a_redirect_next: assert property (
    (take_w && cond_w)
      |=> redirect_out.valid
          && (redirect_out.pc == $past(issue_in.pc) + 64'h4
              + $past(disp_w)
              || !$past(mode64_in)))
    else $error("taken branch did not redirect one cycle later");

  a_no_redirect: assert property (
    !(take_w && cond_w) |=> !redirect_out.valid)
    else $error("redirect without a taken branch");

  a_likely_null: assert property (
    (take_w && dec_w.likely && !cond_w)
      |=> nullify_out ##1 !nullify_out)
    else $error("untaken likely branch left its slot alive");

  a_plain_keeps: assert property (
    (take_w && !dec_w.likely) |=> !nullify_out && slot_out)
    else $error("plain branch nullified its slot");

  a_link_write: assert property (
    (take_w && dec_w.link)
      |=> link_out.we && link_out.idx == 5'h1F
          && (link_out.data == $past(issue_in.pc) + 64'h8
              || !$past(mode64_in)))
    else $error("link register not written with pc plus 8");

  a_link_r31: assert property (
    (take_w && dec_w.link && issue_in.word[25:21] == 5'h1F)
      |=> link_out.we)
    else $error("linking branch on register 31 not executed");

  a_killed_slot: assert property (
    nullify_out |=> !link_out.we && !redirect_out.valid && !nullify_out)
    else $error("nullified slot produced an effect");

  a_slot_state: assert property (
    slot_out == (st_r != ZCB_ST_IDLE))
    else $error("slot flag disagrees with branch state");

  c_taken_link: cover property (take_w && dec_w.link && cond_w);
  c_untaken_likely: cover property (take_w && dec_w.likely && !cond_w);
  c_positive_zero: cover property (take_w && dec_w.positive && !cond_w);
  c_back_to_back: cover property (take_w ##2 take_w);

endmodule

/* rtl/zcb_cond.sv */
// branch condition of a zero compare on one source register value
// purely combinational; fed from the same clock as the caller
`timescale 1ns/10ps
`include "zcb_consts.svh"
module zcb_cond
  import zcb_pkg::*;
(
  // check clock for the embedded assertions only
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // operand and mode
  input  wire logic [63:0] rs_data_in,
  input  wire logic        mode64_in,
  input  wire logic        positive_in,
  // result
  output logic             cond_out
);

  logic sign_w;
  logic nonzero_w;

  always_comb begin
    sign_w    = mode64_in ? rs_data_in[`ZCB_SIGN64]
                          : rs_data_in[`ZCB_SIGN32];
    nonzero_w = mode64_in ? (|rs_data_in)
                          : (|rs_data_in[`ZCB_SIGN32:0]);
    cond_out  = !sign_w && (!positive_in || nonzero_w);
  end

  a_zero_not_pos: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (positive_in && !mode64_in && rs_data_in[31:0] == 32'h0000_0000)
      |-> !cond_out)
    else $error("positive test taken on zero value");

  a_sign_blocks: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode64_in && rs_data_in[63]) |-> !cond_out)
    else $error("branch taken with sign bit set");

endmodule

/* rtl/zcb_consts.svh */
// constants for the zero-compare branch unit: opcodes, fields, offsets
// assumes a 32-bit instruction word and 64-bit program counter and data
`ifndef ZCB_CONSTS_SVH
`define ZCB_CONSTS_SVH

`define ZCB_OP_HI        31
`define ZCB_OP_LO        26
`define ZCB_RS_HI        25
`define ZCB_RS_LO        21
`define ZCB_RT_HI        20
`define ZCB_RT_LO        16
`define ZCB_OFS_HI       15
`define ZCB_SIGN32       31
`define ZCB_SIGN64       63
`define ZCB_EXT32        14
`define ZCB_EXT64        46
`define ZCB_OP_REGISTER_IMMEDIATE_OPCODE_GROUP    6'h01
`define ZCB_OP_POS       6'h07
`define ZCB_OP_POS_LK    6'h17
`define ZCB_RT_NN_LINK   5'h13
`define ZCB_RT_NN        5'h03
`define ZCB_RT_ZERO      5'h00
`define ZCB_LINK_IDX     5'h1F
`define ZCB_SLOT_OFS     64'h0000_0000_0000_0004
`define ZCB_LINK_OFS     64'h0000_0000_0000_0008

`endif

/* rtl/zcb_pkg.sv */
// types shared by the zero-compare branch unit modules
// assumes the constants header is compiled alongside
package zcb_pkg;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [63:0] pc;
    logic [63:0] rs_data;
  } zcb_issue_t;

  typedef struct packed {
    logic        valid;
    logic        link;
    logic        likely;
    logic        positive;
  } zcb_dec_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] pc;
  } zcb_redirect_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  idx;
    logic [63:0] data;
  } zcb_link_t;

  typedef enum logic [1:0] {
    ZCB_ST_IDLE,
    ZCB_ST_SLOT,
    ZCB_ST_KILL
  } zcb_state_t;

endpackage

/* tb/zcb_branch_unit_tb.sv */
// self-checking bench for the zero-compare branch unit
// assumes the unit package is compiled first; the bench drives the issue port
`timescale 1ns/10ps
module zcb_branch_unit_tb
  import zcb_pkg::*;
;
  logic          clk_in;
  logic          rst_n_in;
  logic          m64;
  zcb_issue_t    iss;
  zcb_redirect_t red;
  zcb_link_t     lnk;
  logic          nul;
  logic          slot;
  int            error_cnt;
  int            comparisons;

  zcb_branch_unit dut_u (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .issue_in    (iss),
    .mode64_in   (m64),
    .redirect_out(red),
    .link_out    (lnk),
    .nullify_out (nul),
    .slot_out    (slot)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk64(input string n, input logic [63:0] e,
                       input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // kinds: 0 link likely, 1 not-negative likely, 2 positive, 3 positive likely
  function automatic logic [31:0] mk(input int k, input logic [4:0] r,
                                     input logic [15:0] o);
    case (k)
      0:       mk = {6'h01, r, 5'h13, o};
      1:       mk = {6'h01, r, 5'h03, o};
      2:       mk = {6'h07, r, 5'h00, o};
      default: mk = {6'h17, r, 5'h00, o};
    endcase
  endfunction

  // issue a branch, then its slot word sw, and judge both cycles
  task automatic br(input int k, input logic [4:0] rsi, input logic [15:0] ofs,
                    input logic [63:0] pc, input logic [63:0] rs,
                    input logic md, input logic [31:0] sw);
    logic        sg, tk, lk, ly;
    logic [63:0] d, t, l;
    logic [31:0] t32;
    lk = (k == 0);
    ly = (k != 2);
    sg = md ? rs[63] : rs[31];
    tk = !sg && (k < 2 || (md ? rs != 64'h0 : rs[31:0] != 32'h0));
    d = md ? {{46{ofs[15]}}, ofs, 2'b00}
           : {32'h0, {14{ofs[15]}}, ofs, 2'b00};
    t32 = pc[31:0] + 32'h4 + d[31:0];
    t = md ? pc + 64'h4 + d : {{32{t32[31]}}, t32};
    t32 = pc[31:0] + 32'h8;
    l = md ? pc + 64'h8 : {{32{t32[31]}}, t32};
    @(posedge clk_in);
    #1;
    m64 = md;
    iss = '{1'b1, mk(k, rsi, ofs), pc, rs};
    @(posedge clk_in);
    #1;
    // the slot carries a value that would take a branch if it were decoded
    iss = '{1'b1, sw, pc + 64'h4, 64'h1};
    chk1("redirect", tk, red.valid);
    if (tk) chk64("target", t, red.pc);
    chk1("link_we", lk, lnk.we);
    if (lk) chk64("link_data", l, lnk.data);
    if (lk) chk64("link_idx", 64'h1F, {59'h0, lnk.idx});
    chk1("nullify", ly && !tk, nul);
    chk1("slot", 1'b1, slot);
    @(posedge clk_in);
    #1;
    iss.valid = 1'b0;
    chk1("redirect_end", 1'b0, red.valid);
    chk1("link_end", 1'b0, lnk.we);
    chk1("nullify_end", 1'b0, nul);
    chk1("slot_end", 1'b0, slot);
  endtask

  task automatic t_link();
    br(0, 5'h05, 16'hFFF0, 64'h1_0000_1000, 64'h7FFF_0000_0000_0001,
       1'b1, 32'h0);
    // source is the link register itself and the pc+8 crosses bit 31
    br(0, 5'h1F, 16'h0004, 64'h7FFF_FFF8, 64'h8000_0000, 1'b0,
       32'h0);
  endtask

  task automatic t_nonneg();
    br(1, 5'h02, 16'h7FFF, 64'h7FFF_FFF0, 64'h8000_0000_0000_0000,
       1'b0, 32'h0);
    br(1, 5'h02, 16'h7FFF, 64'h7FFF_FFF0, 64'h8000_0000_0000_0000,
       1'b1, 32'h0);
  endtask

  task automatic t_pos();
    br(2, 5'h03, 16'h8000, 64'h2000, 64'h0, 1'b1, 32'h0);
    br(2, 5'h03, 16'h8000, 64'h2000, 64'h1, 1'b1, 32'h0);
    br(3, 5'h04, 16'h0100, 64'h3000, 64'h1_0000_0000, 1'b0,
       32'h0);
    br(3, 5'h04, 16'h0100, 64'h3000, 64'h1_0000_0000, 1'b1, 32'h0);
  endtask

  task automatic t_slot_branch();
    br(0, 5'h06, 16'h0020, 64'h4000, 64'h0, 1'b1,
       mk(2, 5'h01, 16'h0010));
  endtask

  task automatic t_nomatch();
    logic [31:0] w [3];
    w = '{{6'h01, 5'h02, 5'h11, 16'h0010}, {6'h06, 5'h02, 5'h00, 16'h0010},
          {6'h01, 5'h02, 5'h00, 16'h0010}};
    foreach (w[i]) begin
      @(posedge clk_in);
      #1;
      iss = '{1'b1, w[i], 64'h100, 64'h1};
      @(posedge clk_in);
      #1;
      iss.valid = 1'b0;
      chk1("nomatch_slot", 1'b0, slot);
      chk1("nomatch_redirect", 1'b0, red.valid);
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    error_cnt = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    m64 = 1'b0;
    iss = '0;
    repeat (2) @(posedge clk_in);
    #1;
    chk1("reset_slot", 1'b0, slot);
    chk1("reset_link", 1'b0, lnk.we);
    rst_n_in = 1'b1;
    t_link();
    t_nonneg();
    t_pos();
    t_slot_branch();
    t_nomatch();
    close_out();
  end
endmodule
